// ==== core/pnvm_defines.vh ====
// Purpose: constants for the parallel programming port
// Assumes: 250 MHz core clock
// Notes: command codes, action codes, page geometry, timing counts
`ifndef PNVM_DEFINES_VH
`define PNVM_DEFINES_VH

// Action-select codes on the load strobe
`define PNVM_ACT_ADDR 2'h0
`define PNVM_ACT_DATA 2'h1
`define PNVM_ACT_CMD 2'h2
`define PNVM_ACT_IDLE 2'h3

// Command bytes
`define PNVM_CMD_NOP 8'h00
`define PNVM_CMD_ERASE 8'h80
`define PNVM_CMD_FUSE_WR 8'h40
`define PNVM_CMD_LOCK_WR 8'h20
`define PNVM_CMD_FLASH_WR 8'h10
`define PNVM_CMD_EE_WR 8'h11
`define PNVM_CMD_SIG_RD 8'h08
`define PNVM_CMD_FUSE_RD 8'h04
`define PNVM_CMD_FLASH_RD 8'h02
`define PNVM_CMD_EE_RD 8'h03

// Geometry: largest variant, 32-word flash pages, 4-byte eeprom pages
`define PNVM_FLASH_WORD_BITS 5
`define PNVM_FLASH_PAGES 128
`define PNVM_FLASH_TOP_BIT 11
`define PNVM_EE_BYTE_BITS 2
`define PNVM_EE_TOP_BIT 8

// Timing
`define PNVM_CLK_PERIOD_NS 4
`define PNVM_PULSE_MIN_NS 250
`define PNVM_ENTRY_STABLE_NS 100
`define PNVM_ENTRY_STABLE_CYC ((`PNVM_ENTRY_STABLE_NS + `PNVM_CLK_PERIOD_NS - 1) / `PNVM_CLK_PERIOD_NS)
`define PNVM_ENTRY_TOGGLES 6
`define PNVM_OP_CYC 64
`define PNVM_ERASE_CYC 256

// Reset values: fuse and lock bytes unprogrammed; eeprom save bit position in fuse_hi
`define PNVM_FUSE_RESET 8'hff
`define PNVM_LOCK_RESET 8'hff
`define PNVM_EE_SAVE_BIT 3

`endif

// ==== core/pnvm_port.v ====
// Purpose: parallel high-voltage programming port with paged flash write
// Assumes: all pins asynchronous to clk; memories are register arrays here
// Notes: op_busy time is a fixed stand-in for the cell write time
`include "pnvm_defines.vh"
`timescale 1ns/10ps

module pnvm_port (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Programming pins
	input wire hv_reset,
	input wire load_strobe,
	input wire action_select_lo,
	input wire action_select_hi,
	input wire page_latch_pulse,
	input wire write_n,
	input wire output_enable_n,
	input wire [7:0] data_in,
	output reg [7:0] data_out,
	output reg data_oe,
	output reg ready_busy_flag,
	// Mode status
	output reg prog_mode
);

	localparam ST_IDLE = 2'h0;
	localparam ST_ERASE_MEM = 2'h1;
	localparam ST_ERASE_LOCK = 2'h2;
	localparam ST_PROG = 2'h3;
	localparam [7:0] CAL_BYTE = 8'h5a; // Arbitrary value
	localparam [7:0] SIG0 = 8'h12; // Arbitrary value
	localparam [7:0] SIG1 = 8'h34; // Arbitrary value
	localparam [7:0] SIG2 = 8'h56; // Arbitrary value
	localparam FW = `PNVM_FLASH_WORD_BITS;
	localparam FA = `PNVM_FLASH_TOP_BIT + 1;
	localparam EA = `PNVM_EE_TOP_BIT + 1;
	// Geometry is fixed to the largest variant; smaller parts
	// would simply leave the upper address bits unused
	// (one page write always covers 1 << FW words)

	// Two-stage synchronisers for every pin
	reg [13:0] sync1;
	reg [13:0] sync2;
	reg [13:0] sync3;
	always @(posedge clk) begin
		sync1 <= {hv_reset, load_strobe, action_select_lo, action_select_hi, page_latch_pulse,
			write_n, output_enable_n, data_in[6:0]};
		sync2 <= sync1;
		sync3 <= sync2;
	end
	// Top data bit on its own pair; the pin vector is fourteen wide
	// Same two-stage depth keeps the byte coherent with its strobe
	reg d7_s1;
	reg d7_s2;
	always @(posedge clk) begin
		d7_s1 <= data_in[7];
		d7_s2 <= d7_s1;
	end
	wire hv_s = sync2[13];
	wire ls_s = sync2[12];
	wire xa0_s = sync2[11];
	wire xa1_s = sync2[10];
	wire pl_s = sync2[9];
	wire wr_s = sync2[8];
	wire oe_s = sync2[7];
	wire [7:0] din_s = {d7_s2, sync2[6:0]};
	wire byte_select_one = pl_s;
	wire byte_select_two = xa1_s;
	// Edges from synchronised copies only
	wire ls_rise = ls_s & ~sync3[12];
	wire pl_rise = pl_s & ~sync3[9];
	wire wr_fall = ~wr_s & sync3[8];
	wire hv_rise = hv_s & ~sync3[13];
	wire [3:0] entry_pins = {pl_s, xa1_s, xa0_s, wr_s};

	// Programming mode entry: count strobe toggles, then check pins stay still
	// Toggle count only runs while the voltage is absent
	// A pin change during the check window aborts entry for good,
	// until the voltage is removed and applied again
	reg [2:0] toggles;
	reg [7:0] entry_cnt;
	reg entry_check;
	always @(posedge clk) begin
		if (rst || !hv_s) begin
			prog_mode <= 1'b0;
			entry_check <= 1'b0;
			entry_cnt <= 8'h00;
			if (rst)
				toggles <= 3'h0;
			else if (ls_rise && toggles != 3'h7)
				toggles <= toggles + 3'h1;
		end else if (hv_rise) begin
			entry_check <= (toggles >= `PNVM_ENTRY_TOGGLES) && entry_pins == 4'h0;
			entry_cnt <= 8'h00;
			toggles <= 3'h0;
		end else if (entry_check) begin
			if (entry_pins != 4'h0)
				entry_check <= 1'b0;
			else if (entry_cnt == `PNVM_ENTRY_STABLE_CYC - 1) begin
				entry_check <= 1'b0;
				prog_mode <= 1'b1;
			end else
				entry_cnt <= entry_cnt + 8'h01;
		end
	end

	// Memories
	reg [15:0] flash [0:(1 << FA) - 1];
	reg [7:0] eeprom [0:(1 << EA) - 1];
	reg [15:0] page_buf [0:(1 << FW) - 1];
	reg [7:0] ee_buf [0:3];
	reg [7:0] fuse_lo;
	reg [7:0] fuse_hi;
	reg [7:0] fuse_ext;
	reg [7:0] lock_bits;
	// Flash contents start unknown; only erase or page write set them
	// Fuse and lock bytes reset to unprogrammed

	// Loaded command, address and data
	reg [7:0] cmd;
	reg [7:0] addr_lo;
	reg [7:0] addr_hi;
	reg [7:0] dat_lo;
	reg [7:0] dat_hi;
	reg [1:0] state;
	reg [12:0] op_cnt;
	reg [FA:0] erase_idx;
	reg write_armed;
	wire busy = state != ST_IDLE;
	wire [FA-1:0] flash_addr = {addr_hi[FA-9:0], addr_lo};
	wire [FA-FW-1:0] page_addr = flash_addr[FA-1:FW];
	wire [EA-1:0] ee_addr = {addr_hi[EA-9:0], addr_lo};
	wire [EA-3:0] ee_page = ee_addr[EA-1:`PNVM_EE_BYTE_BITS];

	// Loads on the strobe; command and address retained until reloaded
	// Strobes while busy are dropped; the programmer must wait for
	// ready before reloading
	always @(posedge clk) begin
		if (rst || !prog_mode) begin
			cmd <= `PNVM_CMD_NOP;
			addr_lo <= 8'h00;
			addr_hi <= 8'h00;
			dat_lo <= 8'hff;
			dat_hi <= 8'hff;
			write_armed <= 1'b0;
		end else begin
			if (ls_rise && !busy) begin
				case ({xa1_s, xa0_s})
					`PNVM_ACT_ADDR: begin
						if (byte_select_one)
							addr_hi <= din_s;
						else
							addr_lo <= din_s;
					end
					`PNVM_ACT_DATA: begin
						if (byte_select_one)
							dat_hi <= din_s;
						else
							dat_lo <= din_s;
					end
					`PNVM_ACT_CMD: begin
						cmd <= din_s;
						write_armed <= din_s != `PNVM_CMD_NOP;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Page buffer latch at the word index in the low address byte
	// Loading command 00 also wipes the buffer so stale words
	// cannot reach the next page write
	integer i;
	always @(posedge clk) begin
		if (rst || (ls_rise && {xa1_s, xa0_s} == `PNVM_ACT_CMD && din_s == `PNVM_CMD_NOP)) begin
			for (i = 0; i < (1 << FW); i = i + 1)
				page_buf[i] <= 16'hffff;
			for (i = 0; i < 4; i = i + 1)
				ee_buf[i] <= 8'hff;
		end else if (pl_rise && prog_mode && !busy) begin
			if (cmd == `PNVM_CMD_FLASH_WR)
				page_buf[addr_lo[FW-1:0]] <= {dat_hi, dat_lo};
			else if (cmd == `PNVM_CMD_EE_WR)
				ee_buf[addr_lo[1:0]] <= dat_lo;
		end
	end

	// Operation sequencer, memory updates and ready/busy
	// Own loop index, so no variable is shared between processes
	integer j;
	always @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
			op_cnt <= 13'h0000;
			erase_idx <= {(FA + 1){1'b0}};
			fuse_lo <= `PNVM_FUSE_RESET;
			fuse_hi <= `PNVM_FUSE_RESET;
			fuse_ext <= `PNVM_FUSE_RESET;
			lock_bits <= `PNVM_LOCK_RESET;
			ready_busy_flag <= 1'b1;
		end else begin
			case (state)
				ST_IDLE: begin
					ready_busy_flag <= 1'b1;
					if (wr_fall && prog_mode && write_armed) begin
						op_cnt <= 13'h0000;
						erase_idx <= {(FA + 1){1'b0}};
						case (cmd)
							`PNVM_CMD_ERASE: begin
								state <= ST_ERASE_MEM;
								ready_busy_flag <= 1'b0;
							end
							`PNVM_CMD_FLASH_WR: begin
								for (j = 0; j < (1 << FW); j = j + 1)
									flash[{page_addr, j[FW-1:0]}] <= page_buf[j];
								state <= ST_PROG;
								ready_busy_flag <= 1'b0;
							end
							`PNVM_CMD_EE_WR: begin
								for (j = 0; j < 4; j = j + 1)
									eeprom[{ee_page, j[1:0]}] <= ee_buf[j];
								state <= ST_PROG;
								ready_busy_flag <= 1'b0;
							end
							`PNVM_CMD_FUSE_WR: begin
								if (byte_select_one)
									fuse_hi <= dat_lo;
								else if (byte_select_two)
									fuse_ext <= dat_lo;
								else
									fuse_lo <= dat_lo;
								state <= ST_PROG;
								ready_busy_flag <= 1'b0;
							end
							`PNVM_CMD_LOCK_WR: begin
								lock_bits <= lock_bits & dat_lo; // Only programs, erase clears
								state <= ST_PROG;
								ready_busy_flag <= 1'b0;
							end
							default: begin
							end
						endcase
					end
				end
				ST_ERASE_MEM: begin
					// One flash word per cycle; one eeprom byte per cycle in the first 1 << EA cycles, only while fuse_hi save bit is 1
					flash[erase_idx[FA-1:0]] <= 16'hffff;
					if (fuse_hi[`PNVM_EE_SAVE_BIT] && erase_idx < (1 << EA))
						eeprom[erase_idx[EA-1:0]] <= 8'hff;
					if (erase_idx == (1 << FA) - 1)
						state <= ST_ERASE_LOCK;
					erase_idx <= erase_idx + 1'b1;
				end
				// Lock bits wait for the last flash word so a cut erase
				// never leaves an unlocked part with old code in it
				ST_ERASE_LOCK: begin
					lock_bits <= `PNVM_LOCK_RESET;
					state <= ST_PROG;
				end
				// Fixed stand-in for the cell write time; loads are refused
				// until it runs out
				ST_PROG: begin
					if (op_cnt == `PNVM_OP_CYC - 1)
						state <= ST_IDLE;
					op_cnt <= op_cnt + 13'h0001;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Read mux and bus drive, only while output enable is low
	reg [7:0] next_data;
	always @* begin
		next_data = 8'hff;
		case (cmd)
			`PNVM_CMD_FLASH_RD:
				next_data = byte_select_one ? flash[flash_addr][15:8] : flash[flash_addr][7:0];
			`PNVM_CMD_EE_RD:
				next_data = eeprom[ee_addr];
			`PNVM_CMD_FUSE_RD: begin
				case ({byte_select_two, byte_select_one})
					2'h0: next_data = fuse_lo;
					2'h1: next_data = lock_bits;
					2'h2: next_data = fuse_ext;
					default: next_data = fuse_hi;
				endcase
			end
			// Signature bytes sit in their own space, picked by the low
			// address byte; byte_select_one high returns CAL_BYTE instead
			`PNVM_CMD_SIG_RD: begin
				if (byte_select_one)
					next_data = CAL_BYTE;
				else if (addr_lo == 8'h00)
					next_data = SIG0;
				else if (addr_lo == 8'h01)
					next_data = SIG1;
				else
					next_data = SIG2;
			end
			default: next_data = 8'hff;
		endcase
	end

	// Enable follows the synchronised pin, so the bus turns round
	// a few clocks after output enable moves
	always @(posedge clk) begin
		if (rst) begin
			data_out <= 8'h00;
			data_oe <= 1'b0;
		end else begin
			data_oe <= prog_mode && !oe_s;
			data_out <= next_data;
		end
	end

endmodule // pnvm_port

// ==== tb/pnvm_prog_bus.sv ====
// Purpose: programmer side of the shared data bus
// Assumes: no pull on the bus lines
// Notes: released bus shows a pattern that changes each cycle
`timescale 1ns/10ps
module pnvm_prog_bus (
	// Clock
	input wire clk,
	// Both drivers
	input wire [7:0] prog_data,
	input wire prog_en,
	input wire [7:0] dut_data,
	input wire dut_oe,
	// Resolved bus
	output wire [7:0] bus
);
	reg [7:0] last = 8'h00;
	// Stale value must never pass for read data
	always @(posedge clk) begin
		last <= bus;
	end
	assign bus = dut_oe ? dut_data : (prog_en ? prog_data : ~last);
endmodule // pnvm_prog_bus

// ==== tb/pnvm_port_monitor.sv ====
// Purpose: port checker for the programming port
// Assumes: one clock domain, rst active high
// Notes: bound to pnvm_port below
`timescale 1ns/10ps
module pnvm_port_monitor (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Pins
	input wire hv_reset,
	input wire load_strobe,
	input wire action_select_lo,
	input wire action_select_hi,
	input wire page_latch_pulse,
	input wire write_n,
	input wire output_enable_n,
	input wire [7:0] data_in,
	input wire [7:0] data_out,
	input wire data_oe,
	input wire ready_busy_flag,
	input wire prog_mode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	reg [12:0] busy_cnt;
	// Erase is longer than any delay range, so count it
	always @(posedge clk) begin
		if (rst || ready_busy_flag) busy_cnt <= 13'h0;
		else busy_cnt <= busy_cnt + 13'h1;
	end
	sequence s_busy_start; $fell(ready_busy_flag); endsequence
	sequence s_busy_hold; !ready_busy_flag [*8]; endsequence
	property p_rst; $fell(rst) |-> ready_busy_flag && !data_oe && !prog_mode; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_busy_len; s_busy_start |-> s_busy_hold; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy too short");
	property p_busy_cause; s_busy_start |-> !$past(write_n) && prog_mode; endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
	property p_busy_max; busy_cnt < 13'h1130; endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy never ends");
	property p_oe_mode; data_oe |-> prog_mode; endproperty
	a_oe_mode: assert property (p_oe_mode) else $error("drive out of mode");
	property p_oe_cause; $rose(data_oe) |-> !$past(output_enable_n, 2); endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("drive without enable");
	property p_oe_drop; output_enable_n [*8] |-> !data_oe; endproperty
	a_oe_drop: assert property (p_oe_drop) else $error("bus still driven");
	property p_exit; !hv_reset [*6] |-> !prog_mode; endproperty
	a_exit: assert property (p_exit) else $error("mode held without voltage");
	property p_entry;
		$rose(prog_mode) |-> hv_reset && $past(hv_reset, 20) &&
			!$past(write_n | action_select_lo | action_select_hi | page_latch_pulse, 2);
	endproperty
	a_entry: assert property (p_entry) else $error("bad mode entry");
endmodule // pnvm_port_monitor
bind pnvm_port pnvm_port_monitor u_mon (.clk(clk), .rst(rst), .hv_reset(hv_reset),
	.load_strobe(load_strobe), .action_select_lo(action_select_lo),
	.action_select_hi(action_select_hi), .page_latch_pulse(page_latch_pulse),
	.write_n(write_n), .output_enable_n(output_enable_n), .data_in(data_in),
	.data_out(data_out), .data_oe(data_oe), .ready_busy_flag(ready_busy_flag),
	.prog_mode(prog_mode));

// ==== tb/pnvm_port_tb.sv ====
// Purpose: self-checking bench for the programming port
// Assumes: pins held 63 clocks per level
// Notes: flash write, read back, erase
`timescale 1ns/10ps
`include "pnvm_defines.vh"
module pnvm_port_tb;
	reg clk = 0, rst = 1, hv = 0, ls = 0, alo = 0, ahi = 0, pl = 0, wn = 0, oen = 1, pen = 0;
	reg [7:0] pd = 8'h00;
	wire [7:0] bus, dout;
	wire doe, rdy, mode;
	integer errors = 0, checks_done = 0, cyc = 0, i;
	pnvm_port u_dut (.clk(clk), .rst(rst), .hv_reset(hv), .load_strobe(ls),
		.action_select_lo(alo), .action_select_hi(ahi), .page_latch_pulse(pl),
		.write_n(wn), .output_enable_n(oen), .data_in(bus), .data_out(dout),
		.data_oe(doe), .ready_busy_flag(rdy), .prog_mode(mode));
	pnvm_prog_bus u_bus (.clk(clk), .prog_data(pd), .prog_en(pen && oen),
		.dut_data(dout), .dut_oe(doe), .bus(bus));
	// Clock, 4 ns period
	initial begin
		forever #2 clk = ~clk;
	end
	task final_report;
		begin
			$display("errors=%0d checks_done=%0d", errors, checks_done);
			if (errors == 0 && checks_done > 0) $display("TB: PASS");
			else $display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input [7:0] seen, input [7:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("Error %0t: got %h want %h", $time, seen, exp);
			end
		end
	endtask
	// Every level stands 250 ns at least
	task hold;
		repeat (63) @(posedge clk);
	endtask
	task load(input [1:0] act, input bs, input [7:0] d);
		begin
			{ahi, alo} <= act;
			pl <= bs;
			pd <= d;
			pen <= 1'b1;
			hold;
			ls <= 1'b1;
			hold;
			ls <= 1'b0;
			hold;
		end
	endtask
	task wr;
		begin
			wn <= 1'b0;
			repeat (10) @(posedge clk);
			#1 chk({7'h0, rdy}, 8'h00);
			hold;
			wn <= 1'b1;
			for (i = 0; i < 6000 && rdy !== 1'b1; i = i + 1) @(posedge clk);
			#1 chk({7'h0, rdy}, 8'h01);
			hold;
		end
	endtask
	// Programmer lets go of the bus on the same clock as it enables output
	task rd(input bs, input [7:0] exp);
		begin
			pen <= 1'b0;
			pl <= bs;
			oen <= 1'b0;
			hold;
			#1 chk(bus, exp);
			chk({7'h0, doe}, 8'h01);
			oen <= 1'b1;
			hold;
		end
	endtask
	task t_flash;
		begin
			load(`PNVM_ACT_CMD, 1'b0, `PNVM_CMD_FLASH_WR);
			load(`PNVM_ACT_ADDR, 1'b0, 8'h25);
			load(`PNVM_ACT_DATA, 1'b0, 8'ha5);
			load(`PNVM_ACT_DATA, 1'b1, 8'h5a);
			pl <= 1'b0;
			hold;
			pl <= 1'b1;
			hold;
			pl <= 1'b0;
			load(`PNVM_ACT_ADDR, 1'b1, 8'h03);
			wr;
			load(`PNVM_ACT_CMD, 1'b0, `PNVM_CMD_NOP);
			load(`PNVM_ACT_CMD, 1'b0, `PNVM_CMD_FLASH_RD);
			load(`PNVM_ACT_ADDR, 1'b1, 8'h03);
			load(`PNVM_ACT_ADDR, 1'b0, 8'h25);
			rd(1'b0, 8'ha5);
			rd(1'b1, 8'h5a);
		end
	endtask
	// Address kept, read reloads only the command
	task t_erase;
		begin
			load(`PNVM_ACT_CMD, 1'b0, `PNVM_CMD_ERASE);
			wr;
			load(`PNVM_ACT_CMD, 1'b0, `PNVM_CMD_FLASH_RD);
			rd(1'b0, 8'hff);
			rd(1'b1, 8'hff);
		end
	endtask
	// EEPROM page write of one byte, then read back
	task t_ee;
		begin
			load(`PNVM_ACT_CMD, 1'b0, `PNVM_CMD_EE_WR);
			load(`PNVM_ACT_ADDR, 1'b1, 8'h01);
			load(`PNVM_ACT_ADDR, 1'b0, 8'h06);
			load(`PNVM_ACT_DATA, 1'b0, 8'h3c);
			pl <= 1'b1;
			hold;
			pl <= 1'b0;
			hold;
			wr;
			load(`PNVM_ACT_CMD, 1'b0, `PNVM_CMD_EE_RD);
			rd(1'b0, 8'h3c);
		end
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			errors = errors + 1;
			final_report;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk({5'h0, rdy, doe, mode}, 8'h04);
		for (i = 0; i < 6; i = i + 1) begin
			ls <= 1'b1;
			hold;
			ls <= 1'b0;
			hold;
		end
		hv <= 1'b1;
		repeat (40) @(posedge clk);
		#1 chk({7'h0, mode}, 8'h01);
		repeat (12500) @(posedge clk);
		wn <= 1'b1;
		hold;
		t_flash;
		t_erase;
		t_ee;
		final_report;
	end
endmodule // pnvm_port_tb
